// [shared/ssc_defines.vh]
`ifndef SSC_DEFINES_VH
`define SSC_DEFINES_VH

// register offsets inside one channel window (byte address bits [4:0])
`define SSC_OFS_MODE 5'h00
`define SSC_OFS_ACTION 5'h04
`define SSC_OFS_SELECT 5'h08
`define SSC_OFS_FILT 5'h0c
`define SSC_OFS_LOW 5'h10
`define SSC_OFS_HIGH 5'h14
`define SSC_OFS_HYST 5'h18
`define SSC_OFS_STATUS 5'h1c
// channel windows sit at 0x00 and 0x20, the shared page at 0x40
`define SSC_PAGE_SHARED 3'h2
`define SSC_OFS_CODE0 5'h00
`define SSC_OFS_CODE1 5'h04
`define SSC_OFS_FILTERED0 5'h08
`define SSC_OFS_FILTERED1 5'h0c

// comparison modes
`define SSC_MODE_OFF 3'h0
`define SSC_MODE_LOW 3'h1
`define SSC_MODE_HIGH 3'h2
`define SSC_MODE_ABS_LOW 3'h3
`define SSC_MODE_ABS_HIGH 3'h4
`define SSC_MODE_BOTH 3'h5
`define SSC_MODE_ABS_BOTH 3'h6
`define SSC_MODE_HYST 3'h7

// actions
`define SSC_ACT_NONE 2'h0
`define SSC_ACT_WARN 2'h1
`define SSC_ACT_FAULT 2'h2
`define SSC_ACT_FAULT_RUN 2'h3

// reset values
`define SSC_RST_MODE 3'h0
`define SSC_RST_ACTION 2'h0
`define SSC_RST_SELECT 4'h0
`define SSC_RST_FILT 15'h0000
`define SSC_RST_LIMIT 32'h00000000
`define SSC_RST_HYST 32'h00000000

// filter time in ms (1000 counts per second), upper bound 30.000 s
`define SSC_FILT_MAX_MS 15'h7530
// hysteresis upper bound 100000.00 in hundredths
`define SSC_HYST_MAX 32'h00989680

// event codes: {fault code, warning code}
`define SSC_CODE_CH0 32'h80b3a8b3
`define SSC_CODE_CH1 32'h80b4a8b4

// divide steps run 0..last, one quotient bit each
`define SSC_DIV_LAST 6'h2f

`endif

// [logic/ssc_supervisor.v]
// The Avalon-MM interface to the registers and the address map were left to the implementer.
`timescale 1ns/1ps
`include "ssc_defines.vh"

module ssc_supervisor #(
  parameter NSRC = 4
) (
  input wire core_clk_in,
  input wire rst_in,
  input wire [7:0] avs_address_in,
  input wire avs_read_in,
  input wire avs_write_in,
  input wire [31:0] avs_writedata_in,
  input wire [3:0] avs_byteenable_in,
  output reg [31:0] avs_readdata_out,
  output reg avs_waitrequest_out,
  input wire sample_in,
  input wire motor_running_in,
  input wire [NSRC*32-1:0] signal_in,
  output reg [1:0] cond_out,
  output reg [1:0] warn_out,
  output reg [1:0] fault_out,
  output reg fault_common_out
);

  // filter sequencer phases
  localparam PH_IDLE = 2'h0;
  localparam PH_DIV = 2'h1;
  localparam PH_QUOT = 2'h2;
  localparam PH_EVAL = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  function [31:0] merge_be;
    input [31:0] old;
    input [31:0] data;
    input [3:0] be;
    integer b;
    begin
      merge_be = old;
      for (b = 0; b < 4; b = b + 1) begin
        if (be[b]) begin
          merge_be[b*8 +: 8] = data[b*8 +: 8];
        end
      end
    end
  endfunction

  function [33:0] mag34;
    input [33:0] v;
    begin
      mag34 = v[33] ? (~v + 34'h000000001) : v;
    end
  endfunction

  // signed compares on 34-bit copies, so limits at the extremes cannot wrap
  function lt34;
    input [33:0] a;
    input [33:0] b;
    begin
      lt34 = $signed(a) < $signed(b);
    end
  endfunction

  function gt34;
    input [33:0] a;
    input [33:0] b;
    begin
      gt34 = $signed(a) > $signed(b);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // bus slave: one wait cycle, write lands on the edge waitrequest is seen low
  wire wr_commit;
  reg [31:0] next_readdata;

  reg [2:0] mode [0:1];
  reg [1:0] action [0:1];
  reg [3:0] select [0:1];
  reg [14:0] filt [0:1];
  reg [31:0] low_lim [0:1];
  reg [31:0] high_lim [0:1];
  reg [31:0] hyst [0:1];
  reg [31:0] filtered [0:1];

  assign wr_commit = avs_write_in & ~avs_waitrequest_out;

  // read data loaded on the taking edge, so it stands when waitrequest drops
  always @(posedge core_clk_in) begin
    if (rst_in) begin
      avs_waitrequest_out <= 1'b1;
      avs_readdata_out <= 32'h00000000;
    end else if (avs_waitrequest_out && (avs_read_in || avs_write_in)) begin
      avs_waitrequest_out <= 1'b0;
      avs_readdata_out <= avs_read_in ? next_readdata : 32'h00000000;
    end else begin
      avs_waitrequest_out <= 1'b1;
    end
  end

  always @* begin
    next_readdata = 32'h00000000;
    if (avs_address_in[7:5] < 3'h2) begin
      case (avs_address_in[4:0])
        `SSC_OFS_MODE: next_readdata = {29'h0, mode[avs_address_in[5]]};
        `SSC_OFS_ACTION: next_readdata = {30'h0, action[avs_address_in[5]]};
        `SSC_OFS_SELECT: next_readdata = {28'h0, select[avs_address_in[5]]};
        `SSC_OFS_FILT: next_readdata = {17'h0, filt[avs_address_in[5]]};
        `SSC_OFS_LOW: next_readdata = low_lim[avs_address_in[5]];
        `SSC_OFS_HIGH: next_readdata = high_lim[avs_address_in[5]];
        `SSC_OFS_HYST: next_readdata = hyst[avs_address_in[5]];
        `SSC_OFS_STATUS: begin
          next_readdata = {29'h0, fault_out[avs_address_in[5]],
                           warn_out[avs_address_in[5]], cond_out[avs_address_in[5]]};
        end
        default: next_readdata = 32'h00000000;
      endcase
    end else if (avs_address_in[7:5] == `SSC_PAGE_SHARED) begin
      case (avs_address_in[4:0])
        `SSC_OFS_CODE0: next_readdata = `SSC_CODE_CH0;
        `SSC_OFS_CODE1: next_readdata = `SSC_CODE_CH1;
        `SSC_OFS_FILTERED0: next_readdata = filtered[0];
        `SSC_OFS_FILTERED1: next_readdata = filtered[1];
        default: next_readdata = 32'h00000000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  wire [1:0] run_fault_req;

  always @(posedge core_clk_in) begin
    if (rst_in) begin
      fault_common_out <= 1'b0;
    end else begin
      fault_common_out <= |run_fault_req;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : chan
      wire hit;
      wire [31:0] wm;
      reg [31:0] src;
      reg [1:0] phase;
      reg [47:0] acc;
      reg [47:0] num;
      reg [16:0] rem;
      reg [5:0] cnt;
      reg neg;
      reg hyst_set;
      reg [47:0] next_acc;
      reg [16:0] rem_shift;
      reg [33:0] ys, lo, hi, ay, alo, ahi, up_th, dn_th;
      reg next_hyst;
      reg next_cond;
      wire [16:0] divisor;

      assign hit = wr_commit && (avs_address_in[7:5] == g);
      assign wm = merge_be(32'h00000000, avs_writedata_in, avs_byteenable_in);
      assign divisor = {2'b00, filt[g]} + 17'h00001;
      assign run_fault_req[g] = cond_out[g] && (action[g] == `SSC_ACT_FAULT_RUN)
                                && motor_running_in;

      // registers take the lanes enabled and keep the others; the filter time takes disabled lanes as zero
      always @(posedge core_clk_in) begin
        if (rst_in) begin
          mode[g] <= `SSC_RST_MODE;
          action[g] <= `SSC_RST_ACTION;
          select[g] <= `SSC_RST_SELECT;
          filt[g] <= `SSC_RST_FILT;
          low_lim[g] <= `SSC_RST_LIMIT;
          high_lim[g] <= `SSC_RST_LIMIT;
          hyst[g] <= `SSC_RST_HYST;
        end else if (hit) begin
          case (avs_address_in[4:0])
            `SSC_OFS_MODE: begin
              if (avs_byteenable_in[0]) mode[g] <= wm[2:0];
            end
            `SSC_OFS_ACTION: begin
              if (avs_byteenable_in[0]) action[g] <= wm[1:0];
            end
            `SSC_OFS_SELECT: begin
              if (avs_byteenable_in[0]) select[g] <= wm[3:0];
            end
            `SSC_OFS_FILT: begin
              // out-of-range times clamp to the 30 s ceiling
              if (wm[31:15] != 17'h0 || wm[14:0] > `SSC_FILT_MAX_MS) begin
                filt[g] <= `SSC_FILT_MAX_MS;
              end else begin
                filt[g] <= wm[14:0];
              end
            end
            `SSC_OFS_LOW: low_lim[g] <= merge_be(low_lim[g], avs_writedata_in,
                                                 avs_byteenable_in);
            `SSC_OFS_HIGH: high_lim[g] <= merge_be(high_lim[g], avs_writedata_in,
                                                   avs_byteenable_in);
            `SSC_OFS_HYST: begin
              // negative or oversize ranges clamp, keeping the band sane
              if (merge_be(hyst[g], avs_writedata_in, avs_byteenable_in)
                  > `SSC_HYST_MAX) begin
                hyst[g] <= `SSC_HYST_MAX;
              end else begin
                hyst[g] <= merge_be(hyst[g], avs_writedata_in, avs_byteenable_in);
              end
            end
            default: begin
            end
          endcase
        end
      end

      integer k;
      always @* begin
        src = 32'h00000000;
        for (k = 0; k < NSRC; k = k + 1) begin
          if (select[g] == k + 1) begin
            src = signal_in[k*32 +: 32];
          end
        end
      end

      always @* begin
        next_acc = acc + {{16{src[31]}}, src} - {{16{filtered[g][31]}}, filtered[g]};
        rem_shift = {rem[15:0], num[47]};
        ys = {{2{filtered[g][31]}}, filtered[g]};
        lo = {{2{low_lim[g][31]}}, low_lim[g]};
        hi = {{2{high_lim[g][31]}}, high_lim[g]};
        ay = mag34(ys);
        alo = mag34(lo);
        ahi = mag34(hi);
        up_th = hi + {3'b000, hyst[g][31:1]};
        dn_th = hi - {3'b000, hyst[g][31:1]};
        next_hyst = hyst_set ? !lt34(ys, dn_th)
                             : gt34(ys, up_th);
        case (mode[g])
          `SSC_MODE_LOW: next_cond = lt34(ys, lo);
          `SSC_MODE_HIGH: next_cond = gt34(ys, hi);
          `SSC_MODE_ABS_LOW: next_cond = ay < alo;
          `SSC_MODE_ABS_HIGH: next_cond = ay > ahi;
          `SSC_MODE_BOTH: begin
            next_cond = lt34(ys, lo) || gt34(ys, hi);
          end
          `SSC_MODE_ABS_BOTH: next_cond = (ay < alo) || (ay > ahi);
          `SSC_MODE_HYST: next_cond = next_hyst;
          default: next_cond = 1'b0;
        endcase
      end

      // filter: acc holds the output scaled by (n+1), so y settles exactly on x
      always @(posedge core_clk_in) begin
        if (rst_in) begin
          phase <= PH_IDLE;
          acc <= 48'h000000000000;
          num <= 48'h000000000000;
          rem <= 17'h00000;
          cnt <= 6'h00;
          neg <= 1'b0;
          hyst_set <= 1'b0;
          filtered[g] <= 32'h00000000;
          cond_out[g] <= 1'b0;
        end else begin
          case (phase)
            PH_IDLE: begin
              // a sample arriving mid-computation is skipped
              if (sample_in) begin
                if (filt[g] == 15'h0000) begin
                  acc <= {{16{src[31]}}, src};
                  filtered[g] <= src;
                  phase <= PH_EVAL;
                end else begin
                  acc <= next_acc;
                  neg <= next_acc[47];
                  num <= next_acc[47] ? (~next_acc + 48'h000000000001) : next_acc;
                  rem <= 17'h00000;
                  cnt <= 6'h00;
                  phase <= PH_DIV;
                end
              end
            end
            PH_DIV: begin
              if (rem_shift >= divisor) begin
                rem <= rem_shift - divisor;
                num <= {num[46:0], 1'b1};
              end else begin
                rem <= rem_shift;
                num <= {num[46:0], 1'b0};
              end
              cnt <= cnt + 6'h01;
              if (cnt == `SSC_DIV_LAST) begin
                phase <= PH_QUOT;
              end
            end
            PH_QUOT: begin
              filtered[g] <= neg ? (~num[31:0] + 32'h00000001) : num[31:0];
              phase <= PH_EVAL;
            end
            PH_EVAL: begin
              hyst_set <= (mode[g] == `SSC_MODE_HYST) ? next_hyst : 1'b0;
              cond_out[g] <= next_cond;
              phase <= PH_IDLE;
            end
            default: phase <= PH_IDLE;
          endcase
          // band state forgotten as soon as the mode leaves hysteresis
          if (mode[g] != `SSC_MODE_HYST) begin
            hyst_set <= 1'b0;
          end
          if (mode[g] == `SSC_MODE_OFF) begin
            cond_out[g] <= 1'b0;
          end
        end
      end

      // action only routes the condition; status bit untouched by it
      always @(posedge core_clk_in) begin
        if (rst_in) begin
          warn_out[g] <= 1'b0;
          fault_out[g] <= 1'b0;
        end else begin
          warn_out[g] <= cond_out[g] && (action[g] == `SSC_ACT_WARN);
          fault_out[g] <= cond_out[g] && (action[g] == `SSC_ACT_FAULT);
        end
      end
    end
  endgenerate

endmodule

// [verif/ssc_supervisor_sva.sv]
`timescale 1ns/1ps
module ssc_chk (
  input wire core_clk_in,
  input wire rst_in,
  input wire avs_read_in,
  input wire avs_write_in,
  input wire [31:0] avs_readdata_out,
  input wire avs_waitrequest_out,
  input wire sample_in,
  input wire [1:0] cond_out,
  input wire [1:0] warn_out,
  input wire [1:0] fault_out,
  input wire fault_common_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  wire req = avs_read_in | avs_write_in;
  reg [6:0] since;
  // the slowest evaluation lands 50 edges after its tick
  always @(posedge core_clk_in) begin
    if (rst_in || sample_in || req) begin
      since <= 7'h00;
    end else if (since != 7'h7f) begin
      since <= since + 7'h01;
    end
  end
  ////////////////////////////////////////////////////////////
  a_wait_answer: assert property (req && avs_waitrequest_out |=> !avs_waitrequest_out)
    else $error("no answer");
  a_wait_single: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
    else $error("wait low too long");
  a_wait_idle: assert property (!req && avs_waitrequest_out |=> avs_waitrequest_out)
    else $error("answer without request");
  a_data_stands: assert property (!(req && avs_waitrequest_out) |=> $stable(avs_readdata_out))
    else $error("read data moved");
  a_reset_quiet: assert property (disable iff (1'b0) rst_in |=> avs_waitrequest_out &&
    !(|{cond_out, warn_out, fault_out, fault_common_out})) else $error("reset not quiet");
  a_event_cause: assert property (((warn_out | fault_out) & ~$past(cond_out)) == 2'b00)
    else $error("event without condition");
  a_event_excl: assert property ((warn_out & fault_out) == 2'b00)
    else $error("warning and fault together");
  a_common_cause: assert property (fault_common_out |-> $past(|cond_out))
    else $error("common fault without condition");
  a_cond_sampled: assert property ($changed(cond_out) |-> since < 7'h3c)
    else $error("condition moved between samples");
  cover property (|warn_out);
  cover property (|fault_out);
  cover property (fault_common_out);
endmodule

bind ssc_supervisor ssc_chk i_ssc_chk (.core_clk_in, .rst_in, .avs_read_in, .avs_write_in,
  .avs_readdata_out, .avs_waitrequest_out, .sample_in, .cond_out, .warn_out, .fault_out,
  .fault_common_out);

// [verif/ssc_src_model.sv]
`timescale 1ns/1ps
module ssc_src_model (
  input wire core_clk_in,
  input wire rst_in,
  input wire fire_in,
  input wire [1:0] sel_in,
  input wire [31:0] val_in,
  input wire run_in,
  output reg [127:0] signal_out,
  output reg sample_out,
  output reg running_out
);
  always @(posedge core_clk_in) begin
    if (rst_in) begin
      signal_out <= 128'h0;
      sample_out <= 1'b0;
      running_out <= 1'b0;
    end else begin
      // tick rides with the new value so the sample sees it settled
      sample_out <= fire_in;
      if (fire_in) begin
        signal_out[sel_in*32+:32] <= val_in;
        running_out <= run_in;
      end
    end
  end
endmodule

// [verif/tb.sv]
`timescale 1ns/1ps
module tb;
  reg core_clk_in = 1'b0;
  reg rst_in = 1'b1;
  reg [7:0] adr = 8'h00;
  reg rd = 1'b0;
  reg wr = 1'b0;
  reg [31:0] wdat = 32'h0;
  reg fire = 1'b0;
  reg [1:0] fsel = 2'h0;
  reg [31:0] fval = 32'h0;
  reg run = 1'b0;
  reg [3:0] ben = 4'hf;
  wire [31:0] rdat;
  wire wreq;
  wire [127:0] sig;
  wire smp;
  wire mrun;
  wire [1:0] cond;
  wire [1:0] warn;
  wire [1:0] fault;
  wire fcom;
  int fails = 0;
  int tests_run = 0;

  ssc_supervisor i_ssc_supervisor (.core_clk_in(core_clk_in), .rst_in(rst_in),
    .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdat),
    .avs_byteenable_in(ben), .avs_readdata_out(rdat), .avs_waitrequest_out(wreq),
    .sample_in(smp), .motor_running_in(mrun), .signal_in(sig), .cond_out(cond),
    .warn_out(warn), .fault_out(fault), .fault_common_out(fcom));
  ssc_src_model i_ssc_src_model (.core_clk_in(core_clk_in), .rst_in(rst_in), .fire_in(fire),
    .sel_in(fsel), .val_in(fval), .run_in(run), .signal_out(sig), .sample_out(smp),
    .running_out(mrun));

  initial begin
    forever #25 core_clk_in = ~core_clk_in;
  end
  ////////////////////////////////////////////////////////////
  task check(input string nm, input [31:0] got, input [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task give_verdict;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task bus(input bit w, input [7:0] a, input [31:0] d, output [31:0] q);
    int n;
    n = 0;
    @(posedge core_clk_in);
    adr <= a;
    rd <= !w;
    wr <= w;
    wdat <= d;
    do begin
      @(posedge core_clk_in);
      n++;
    end while (wreq !== 1'b0 && n < 20);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    if (n >= 20) begin
      fails++;
      give_verdict;
    end
  endtask

  task wreg(input [7:0] a, input [31:0] d);
    reg [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task rchk(input string nm, input [7:0] a, input [31:0] e);
    reg [31:0] q;
    bus(1'b0, a, 32'h0, q);
    check(nm, q, e);
  endtask

  // one control tick carrying a new source value, then room for the slowest evaluation
  task pulse(input [1:0] s, input [31:0] v, input bit rn);
    @(posedge core_clk_in);
    fire <= 1'b1;
    fsel <= s;
    fval <= v;
    run <= rn;
    @(posedge core_clk_in);
    fire <= 1'b0;
    repeat (60) @(posedge core_clk_in);
  endtask

  // wide arithmetic so limit plus half band cannot wrap
  function bit exp_cond(input [2:0] m, input [31:0] xs, input [31:0] los, input [31:0] his,
    input [31:0] hy, input bit prev);
    longint x, lo, hi, h, ax, alo, ahi;
    x = longint'($signed(xs));
    lo = longint'($signed(los));
    hi = longint'($signed(his));
    h = longint'(hy >> 1);
    ax = x < 0 ? -x : x;
    alo = lo < 0 ? -lo : lo;
    ahi = hi < 0 ? -hi : hi;
    case (m)
      3'h1: exp_cond = x < lo;
      3'h2: exp_cond = x > hi;
      3'h3: exp_cond = ax < alo;
      3'h4: exp_cond = ax > ahi;
      3'h5: exp_cond = x < lo || x > hi;
      3'h6: exp_cond = ax < alo || ax > ahi;
      3'h7: exp_cond = x > hi + h ? 1'b1 : (x < hi - h ? 1'b0 : prev);
      default: exp_cond = 1'b0;
    endcase
  endfunction
  ////////////////////////////////////////////////////////////
  initial begin
    reg [31:0] lo, hi, hy, x;
    reg [7:0] base;
    bit [2:0] m;
    bit [1:0] act;
    bit [1:0] c;
    longint facc, fy;
    bit e;
    bit prev;
    bit r;
    void'($urandom(32'h58b9));
    repeat (3) @(posedge core_clk_in);
    rst_in <= 1'b0;
    for (int k = 0; k < 14; k++) begin
      rchk("defaults", 8'((k / 7) * 32 + (k % 7) * 4), 32'h0);
    end
    rchk("code first", 8'h40, 32'h80b3a8b3);
    wreg(8'h44, 32'h0);
    rchk("code second", 8'h44, 32'h80b4a8b4);
    rchk("unmapped", 8'h80, 32'h0);
    ben <= 4'h1;
    wreg(8'h10, 32'haabbccdd);
    ben <= 4'hf;
    rchk("lane merge", 8'h10, 32'h000000dd);
    wreg(8'h10, 32'h0);
    wreg(8'h0c, 32'h0000ffff);
    rchk("filter clamp", 8'h0c, 32'h00007530);
    wreg(8'h38, 32'hffffffff);
    rchk("band clamp", 8'h38, 32'h00989680);
    // filter time 3: output is accumulator over four, truncated toward zero
    wreg(8'h0c, 32'h3);
    wreg(8'h08, 32'h1);
    facc = 0;
    fy = 0;
    repeat (4) begin
      x = $urandom_range(2400) - 1200;
      pulse(2'h0, x, 1'b0);
      facc = facc + longint'($signed(x)) - fy;
      fy = facc / 4;
      rchk("filter output", 8'h48, 32'(fy));
    end
    wreg(8'h0c, 32'h0);
    for (int i = 0; i < 64; i++) begin
      c = 2'((i / 8) % 2);
      m = 3'(i % 8);
      act = 2'((i / 8 + i) % 4);
      base = c ? 8'h20 : 8'h00;
      lo = $urandom_range(2000) - 1000;
      hi = $urandom_range(2000) - 1000;
      hy = $urandom_range(600);
      wreg(base ^ 8'h20, 32'h0);
      wreg(base, {29'h0, m});
      wreg(base + 8'h04, {30'h0, act});
      wreg(base + 8'h08, c + 1);
      wreg(base + 8'h10, lo);
      wreg(base + 8'h14, hi);
      wreg(base + 8'h18, hy);
      prev = 1'b0;
      repeat (3) begin
        x = $urandom_range(2400) - 1200;
        // equal to the high limit must not flag in the strict modes; in hysteresis it keeps the band state
        if ($urandom_range(3) == 0) x = hi;
        r = 1'($urandom_range(1));
        pulse(c, x, r);
        e = exp_cond(m, x, lo, hi, hy, prev);
        prev = e;
        check("condition", cond[c], e);
        check("warning", warn[c], e && act == 2'h1);
        check("fault", fault[c], e && act == 2'h2);
        check("common fault", fcom, e && act == 2'h3 && r);
        check("idle channel", cond[1 - c], 1'b0);
        rchk("status", base + 8'h1c, {29'h0, e && act == 2'h2, e && act == 2'h1, e});
        rchk("filtered", 8'h48 + {c, 2'b00}, x);
      end
    end
    // second reset in mid-run must bring back the quiet defaults
    @(posedge core_clk_in);
    rst_in <= 1'b1;
    repeat (3) @(posedge core_clk_in);
    rst_in <= 1'b0;
    check("reset condition", cond, 32'h0);
    rchk("reset mode", 8'h20, 32'h0);
    give_verdict;
  end
endmodule
